// [logic/cfc_codec.sv]
// Control field codec: grant bitmap, valid counts, cancel, request fields
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - Bitmap is 72 bits in version 1, slots times subchannels in version 2.
// - Unit numbers map from the top bitmap bit; 1 means allocated.
// - Unit numbering starts at an origin set at connection setup.
// - Timing 1 grants one frame later, timing 2 two frames later.
// - Valid count marks units from frame start; the rest are empty.
// - Counted units form one data unit; other allocated units are empty.
// - Version 1 downlink valid field is 7 bits, uplink 20 bits.
// - Version 2 valid fields hold one sized sub-field per slot.
// - Count includes retransmitted and new units, never empty ones.
// - Retransmitted units come first, in lowest subchannels.
// - Downlink count follows the bitmap timing of its control slot.
// - Uplink count applies to the same frame's uplink data channel.
// - Cancel flag 0 keeps retransmission, 1 aborts it.
// - Downlink cancel follows the bitmap timing of its control slot.
// - Uplink cancel applies to the same frame's uplink data channel.
// - Request bits 7..6: 00 data size, 01 margin, others reserved.
// - Size unit bits 5..4 select message, 100 B, 1 kB, 10 kB.
// - Margin report bits 5..1 carry 0 to 31 dB in 1 dB steps.
// - Short size element is 2-bit group id then 6-bit size.
// - Long size element carries four sizes, groups 0 to 3 in order.
// - Each size reports pending bytes of its whole channel group.
// - Extended margin element is zero reserved bits plus 6-bit index.
module cfc_codec #(
    parameter int unsigned N_SCH = 18,
    parameter int unsigned N_DSL = 4,
    parameter int unsigned N_USL = 4,
    parameter int unsigned N_DST = 1,
    parameter int unsigned N_UST = 1
) (
    // Clock, reset and enable
    input  wire logic                      pclk,
    input  wire logic                      presetn,
    input  wire logic                      clk_en,
    // APB slave
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [7:0]                paddr,
    input  wire logic [31:0]               pwdata,
    output logic      [31:0]               prdata,
    output logic                           pready,
    output logic                           pslverr,
    // Frame timing
    input  wire logic                      frame_tick,
    // Received request field from the peer
    input  wire logic                      rx_req_valid,
    input  wire logic [7:0]                rx_uplink_request_field,
    // Fields toward the air interface
    output cfc_pkg::cfc_dl_s               dl_grant,
    output cfc_pkg::cfc_ul_s               ul_grant,
    output logic      [7:0]                tx_uplink_request_field,
    output cfc_pkg::cfc_mac_s              mac_elems
);

    localparam int unsigned MAPW  = cfc_pkg::MAP_MAX_BITS;
    localparam int unsigned CW    = cfc_pkg::CNT_BITS;
    localparam int unsigned N_SL  = (N_DSL > N_USL) ? N_DSL : N_USL;
    localparam int unsigned V2MAP = N_SL * N_SCH;
    localparam int unsigned DSUBW = $clog2((N_SCH + 1) * N_DST);
    localparam int unsigned USUBW = $clog2((N_SCH + 1) * N_UST);
    localparam int unsigned DV2W  = N_DSL * DSUBW;
    localparam int unsigned UV2W  = N_USL * USUBW;

    // Software registers
    logic [31:0]     ctrl_r;
    logic [MAPW-1:0] map_r;
    logic [31:0]     dltx_r;
    logic [31:0]     ultx_r;
    logic [7:0]      req_r;
    logic [31:0]     gsize01_r;
    logic [31:0]     gsize23_r;
    logic [31:0]     macsel_r;
    // Received request state
    logic [4:0]      rx_size_r;
    logic [4:0]      rx_margin_r;
    logic [1:0]      status_r;
    logic [1:0]      status_nxt;
    // Frame pipeline
    cfc_pkg::cfc_dl_s dl_cur;
    cfc_pkg::cfc_dl_s dl_s1_r;
    cfc_pkg::cfc_dl_s dl_grant_r;
    cfc_pkg::cfc_ul_s ul_grant_r;
    cfc_pkg::cfc_mac_s mac_r;
    logic [7:0]      tx_req_r;
    logic [31:0]     prdata_r;

    // Bus decode
    wire logic access  = psel && penable;
    wire logic wr_en   = access && pwrite && clk_en;
    wire logic rd_take = psel && !penable && !pwrite && clk_en;
    wire logic hit_ctrl  = (paddr == cfc_pkg::OFS_CTRL);
    wire logic hit_map0  = (paddr == cfc_pkg::OFS_MAP0);
    wire logic hit_map1  = (paddr == cfc_pkg::OFS_MAP1);
    wire logic hit_map2  = (paddr == cfc_pkg::OFS_MAP2);
    wire logic hit_dltx  = (paddr == cfc_pkg::OFS_DLTX);
    wire logic hit_ultx  = (paddr == cfc_pkg::OFS_ULTX);
    wire logic hit_req   = (paddr == cfc_pkg::OFS_REQ);
    wire logic hit_gs01  = (paddr == cfc_pkg::OFS_GSIZE01);
    wire logic hit_gs23  = (paddr == cfc_pkg::OFS_GSIZE23);
    wire logic hit_msel  = (paddr == cfc_pkg::OFS_MACSEL);
    wire logic hit_stat  = (paddr == cfc_pkg::OFS_STATUS);
    wire logic hit_frm   = (paddr == cfc_pkg::OFS_FRAME);
    wire logic hit_any   = hit_ctrl | hit_map0 | hit_map1 | hit_map2 |
                           hit_dltx | hit_ultx | hit_req | hit_gs01 |
                           hit_gs23 | hit_msel | hit_stat | hit_frm;

    // Zero wait states; a frozen block stretches the access instead
    assign pready  = clk_en;
    assign pslverr = access && !hit_any;
    assign prdata  = prdata_r;

    // Control fields
    wire logic            ver2    = ctrl_r[cfc_pkg::CTRL_VER_BIT];
    wire logic            timing2 = ctrl_r[cfc_pkg::CTRL_TIM_BIT];
    wire logic [6:0]      origin  = ctrl_r[cfc_pkg::CTRL_ORG_LSB +: 7];
    wire logic [CW-1:0]   retx_cnt = dltx_r[6:0];
    wire logic [CW-1:0]   new_cnt  = dltx_r[cfc_pkg::DLTX_NEW_LSB +: 7];

    // Active bitmap length per protocol version
    wire logic [CW:0] map_len = ver2 ? (CW+1)'(V2MAP)
                                     : (CW+1)'(cfc_pkg::MAP_V1_BITS);

    // Units past the active length are never granted
    logic [MAPW-1:0] len_mask;
    logic [MAPW-1:0] map_eff;
    logic [CW:0]     pre [0:MAPW];
    logic [MAPW-1:0] fill_map;
    logic [MAPW-1:0] retx_map;
    logic [CW-1:0]   valid_cnt;
    wire logic [CW:0] vx = {1'b0, valid_cnt};

    assign pre[0] = '0;

    // Logical unit i sits at bit MAPW-1-i, counted from the top
    genvar gi;
    generate
        for (gi = 0; gi < MAPW; gi++)
        begin : g_unit
            localparam int unsigned B = MAPW - 1 - gi;
            assign len_mask[B] = ((CW+1)'(gi) < map_len);
            assign map_eff[B]  = map_r[B] & len_mask[B];
            assign pre[gi+1]   = pre[gi] + (CW+1)'(map_eff[B]);
            // First counted allocated units carry data, the rest are empty
            assign fill_map[B] = map_eff[B] &
                                 (pre[gi] < vx);
            // Retransmissions ahead of new data in the lowest units
            assign retx_map[B] = map_eff[B] &
                                 (pre[gi] < {1'b0, retx_cnt});
        end
    endgenerate

    // Valid count: retransmitted plus new units, capped by allocation
    logic [CW:0]   req_units;
    logic [CW-1:0] alloc_cnt;
    assign req_units = {1'b0, retx_cnt} + {1'b0, new_cnt};
    assign alloc_cnt = pre[MAPW][CW-1:0];
    assign valid_cnt = (req_units > {1'b0, alloc_cnt}) ? alloc_cnt
                                                       : req_units[CW-1:0];

    // Version 2 downlink filled units per slot, slot 0 in the top bits
    logic [31:0] dl_v2_field;
    genvar gs;
    generate
        for (gs = 0; gs < 32; gs++)
        begin : g_dlv2
            if (gs >= DV2W)
            begin : g_pad
                assign dl_v2_field[gs] = 1'b0;
            end
            else
            begin : g_bit
                localparam int unsigned SLOT = (DV2W - 1 - gs) / DSUBW;
                localparam int unsigned SB   = DSUBW - 1 -
                                               ((DV2W - 1 - gs) % DSUBW);
                localparam int unsigned S0   = SLOT * N_SCH;
                logic [CW:0] slot_cnt;
                assign slot_cnt = ((pre[S0+N_SCH] < vx) ? pre[S0+N_SCH] : vx)
                                  - ((pre[S0] < vx) ? pre[S0] : vx);
                assign dl_v2_field[gs] = slot_cnt[SB];
            end
        end
    endgenerate

    // Current downlink grant as written by software this frame
    always_comb
    begin
        dl_cur             = '0;
        dl_cur.map         = map_eff;
        dl_cur.fill        = fill_map;
        dl_cur.retx        = retx_map;
        dl_cur.valid_cnt   = valid_cnt;
        dl_cur.valid_field = ver2 ? dl_v2_field
                                  : {25'h000_0000, valid_cnt};
        dl_cur.cancel      = dltx_r[cfc_pkg::DLTX_CAN_BIT];
        dl_cur.origin      = origin;
    end

    // Uplink valid field width per version, upper bits forced to zero
    wire logic [31:0] ul_mask = ver2 ? ((32'h0000_0001 << UV2W) - 32'h1)
                                     : 32'h000F_FFFF;

    // Reserved request type codes written by software are refused
    wire logic [1:0] req_wtype = pwdata[7:6];
    wire logic       req_ok    = (req_wtype == cfc_pkg::REQ_DATA_SIZE) ||
                                 (req_wtype == cfc_pkg::REQ_MARGIN);

    // Register writes take effect at the access edge
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_r    <= cfc_pkg::RST_WORD;
            map_r     <= '0;
            dltx_r    <= cfc_pkg::RST_WORD;
            ultx_r    <= cfc_pkg::RST_WORD;
            req_r     <= cfc_pkg::RST_BYTE;
            gsize01_r <= cfc_pkg::RST_WORD;
            gsize23_r <= cfc_pkg::RST_WORD;
            macsel_r  <= cfc_pkg::RST_WORD;
        end
        else if (wr_en)
        begin
            if (hit_ctrl)  ctrl_r    <= pwdata & 32'h0000_7F03;
            if (hit_map0)  map_r[71:40] <= pwdata;
            if (hit_map1)  map_r[39:8]  <= pwdata;
            if (hit_map2)  map_r[7:0]   <= pwdata[31:24];
            if (hit_dltx)  dltx_r    <= pwdata & 32'h0001_7F7F;
            if (hit_ultx)  ultx_r    <= pwdata;
            if (hit_req && req_ok) req_r <= pwdata[7:0];
            if (hit_gs01)  gsize01_r <= pwdata;
            if (hit_gs23)  gsize23_r <= pwdata;
            if (hit_msel)  macsel_r  <= pwdata & 32'h0000_3F03;
        end
    end

    // Received request decode; reserved codes leave all state alone
    wire logic [1:0] rx_type = rx_uplink_request_field[7:6];
    wire logic rx_size = rx_req_valid && clk_en &&
                         (rx_type == cfc_pkg::REQ_DATA_SIZE);
    wire logic rx_marg = rx_req_valid && clk_en &&
                         (rx_type == cfc_pkg::REQ_MARGIN);
    wire logic st_clr  = wr_en && hit_stat;

    // Sticky new-report flags: a report in the clear cycle survives
    always_comb
    begin
        status_nxt = status_r;
        if (st_clr)
            status_nxt = status_r & ~pwdata[1:0];
        if (rx_size)
            status_nxt[cfc_pkg::ST_SIZE_BIT] = 1'b1;
        if (rx_marg)
            status_nxt[cfc_pkg::ST_MARG_BIT] = 1'b1;
    end

    // Capture of received reports
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rx_size_r   <= '0;
            rx_margin_r <= '0;
            status_r    <= '0;
        end
        else if (clk_en)
        begin
            status_r <= status_nxt;
            if (rx_size)
                rx_size_r <= rx_uplink_request_field[5:1];
            if (rx_marg)
                rx_margin_r <= rx_uplink_request_field[5:1];
        end
    end

    // Per-group pending totals saturate into the 6-bit size field
    function automatic logic [5:0] size6(input logic [15:0] bytes);
        size6 = (bytes > 16'h003F) ? 6'h3F : bytes[5:0];
    endfunction : size6

    wire logic [5:0] gsz0 = size6(gsize01_r[15:0]);
    wire logic [5:0] gsz1 = size6(gsize01_r[31:16]);
    wire logic [5:0] gsz2 = size6(gsize23_r[15:0]);
    wire logic [5:0] gsz3 = size6(gsize23_r[31:16]);
    wire logic [1:0] gsel = macsel_r[1:0];
    wire logic [5:0] gsel_size = (gsel == 2'd0) ? gsz0 :
                                 (gsel == 2'd1) ? gsz1 :
                                 (gsel == 2'd2) ? gsz2 : gsz3;

    // Frame pipeline for downlink, same-frame latch for uplink
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            dl_s1_r    <= '0;
            dl_grant_r <= '0;
            ul_grant_r <= '0;
        end
        else if (clk_en && frame_tick)
        begin
            dl_s1_r    <= dl_cur;
            // Timing 2 reaches back one more frame than timing 1
            dl_grant_r <= timing2 ? dl_s1_r : dl_cur;
            ul_grant_r.valid_field <= ultx_r & ul_mask;
            ul_grant_r.cancel <= ultx_r[cfc_pkg::ULTX_CAN_BIT];
        end
    end

    // Outgoing request field and access-sublayer elements
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tx_req_r <= cfc_pkg::RST_BYTE;
            mac_r    <= '0;
        end
        else if (clk_en)
        begin
            tx_req_r <= {req_r[7:1], 1'b0};
            mac_r.short_elem  <= {gsel, gsel_size};
            mac_r.long_elem   <= {gsz0, gsz1, gsz2, gsz3};
            mac_r.margin_elem <= {2'b00,
                                  macsel_r[cfc_pkg::MAC_IDX_LSB +: 6]};
        end
    end

    // Read mux
    logic [31:0] rd_mux;
    always_comb
    begin
        rd_mux = 32'h0000_0000;
        case (1'b1)
            hit_ctrl:  rd_mux = ctrl_r;
            hit_map0:  rd_mux = map_r[71:40];
            hit_map1:  rd_mux = map_r[39:8];
            hit_map2:  rd_mux = {map_r[7:0], 24'h00_0000};
            hit_dltx:  rd_mux = dltx_r;
            hit_ultx:  rd_mux = ultx_r;
            hit_req:   rd_mux = {24'h00_0000, req_r};
            hit_gs01:  rd_mux = gsize01_r;
            hit_gs23:  rd_mux = gsize23_r;
            hit_msel:  rd_mux = macsel_r;
            hit_stat:  rd_mux = {14'h0000, rx_margin_r, 3'b000,
                                 rx_size_r, 3'b000, status_r};
            hit_frm:   rd_mux = {9'h000, alloc_cnt, 1'b0, valid_cnt,
                                 1'b0, dl_grant_r.valid_cnt};
            default:   rd_mux = 32'h0000_0000;
        endcase
    end

    // Read data registered in the setup cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata_r <= cfc_pkg::RST_WORD;
        else if (rd_take)
            prdata_r <= rd_mux;
    end

    assign dl_grant                = dl_grant_r;
    assign ul_grant                = ul_grant_r;
    assign tx_uplink_request_field = tx_req_r;
    assign mac_elems               = mac_r;

endmodule : cfc_codec

`default_nettype wire

// [logic/cfc_pkg.sv]
// Package: constants, field layouts and carriers of the control field codec
package cfc_pkg;

    // Field sizes fixed for protocol version 1
    localparam int unsigned MAP_V1_BITS   = 72;
    localparam int unsigned MAP_MAX_BITS  = 72;
    localparam int unsigned DLV_V1_BITS   = 7;
    localparam int unsigned ULV_V1_BITS   = 20;
    localparam int unsigned VFIELD_BITS   = 32;
    localparam int unsigned CNT_BITS      = 7;
    localparam int unsigned ORG_BITS      = 7;

    // Register byte offsets on the APB window
    localparam int unsigned ADDR_BITS     = 8;
    localparam logic [7:0] OFS_CTRL       = 8'h00;
    localparam logic [7:0] OFS_MAP0       = 8'h04;
    localparam logic [7:0] OFS_MAP1       = 8'h08;
    localparam logic [7:0] OFS_MAP2       = 8'h0C;
    localparam logic [7:0] OFS_DLTX       = 8'h10;
    localparam logic [7:0] OFS_ULTX       = 8'h14;
    localparam logic [7:0] OFS_REQ        = 8'h18;
    localparam logic [7:0] OFS_GSIZE01    = 8'h1C;
    localparam logic [7:0] OFS_GSIZE23    = 8'h20;
    localparam logic [7:0] OFS_MACSEL     = 8'h24;
    localparam logic [7:0] OFS_STATUS     = 8'h28;
    localparam logic [7:0] OFS_FRAME      = 8'h2C;

    // Field positions inside registers
    localparam int unsigned CTRL_VER_BIT  = 0;
    localparam int unsigned CTRL_TIM_BIT  = 1;
    localparam int unsigned CTRL_ORG_LSB  = 8;
    localparam int unsigned DLTX_NEW_LSB  = 8;
    localparam int unsigned DLTX_CAN_BIT  = 16;
    localparam int unsigned ULTX_CAN_BIT  = 31;
    localparam int unsigned MAC_IDX_LSB   = 8;
    localparam int unsigned ST_SIZE_BIT   = 0;
    localparam int unsigned ST_MARG_BIT   = 1;

    // Reset values
    localparam logic [31:0] RST_WORD      = 32'h0000_0000;
    localparam logic [7:0]  RST_BYTE      = 8'h00;

    // Request field type codes in bits 7..6
    typedef enum logic [1:0] {
        REQ_DATA_SIZE = 2'b00,
        REQ_MARGIN    = 2'b01,
        REQ_RSV_A     = 2'b10,
        REQ_RSV_B     = 2'b11
    } cfc_req_type_e;

    // Downlink grant as it reaches the data channel
    typedef struct packed {
        logic [MAP_MAX_BITS-1:0] map;
        logic [MAP_MAX_BITS-1:0] fill;
        logic [MAP_MAX_BITS-1:0] retx;
        logic [VFIELD_BITS-1:0]  valid_field;
        logic [CNT_BITS-1:0]     valid_cnt;
        logic                    cancel;
        logic [ORG_BITS-1:0]     origin;
    } cfc_dl_s;

    // Uplink control that applies within the same frame
    typedef struct packed {
        logic [VFIELD_BITS-1:0] valid_field;
        logic                   cancel;
    } cfc_ul_s;

    // Access-sublayer control elements
    typedef struct packed {
        logic [7:0]  short_elem;
        logic [23:0] long_elem;
        logic [7:0]  margin_elem;
    } cfc_mac_s;

endpackage : cfc_pkg

// [tb/cfc_codec_chk.sv]
// Checker: port-level assertions for the control field codec
`timescale 1ns/1ps
`default_nettype none
module cfc_codec_chk (
    // Clock and reset
    input wire logic              pclk,
    input wire logic              presetn,
    input wire logic              clk_en,
    // APB
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [7:0]        paddr,
    input wire logic [31:0]       pwdata,
    input wire logic              pready,
    input wire logic              pslverr,
    // Frame and fields
    input wire logic              frame_tick,
    input wire logic              rx_req_valid,
    input wire cfc_pkg::cfc_dl_s  dl_grant,
    input wire cfc_pkg::cfc_ul_s  ul_grant,
    input wire logic [7:0]        tx_uplink_request_field,
    input wire cfc_pkg::cfc_mac_s mac_elems
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Completed writes; the grant may land one or two edges after a tick
    wire acc = psel && penable && pready;
    wire tk  = frame_tick && clk_en;
    wire wq  = acc && pwrite && paddr == cfc_pkg::OFS_REQ && !pwdata[7];
    wire wm  = acc && pwrite && paddr == cfc_pkg::OFS_MACSEL;

    chk_dl_hold: assert property (!$past(tk) && !$past(tk, 2) |->
        $stable(dl_grant)) else $error("dl grant moved off a tick");
    chk_ul_hold: assert property (!$past(tk) && !$past(tk, 2) |->
        $stable(ul_grant)) else $error("ul grant moved off a tick");
    chk_fill_alloc: assert property (
        (dl_grant.fill & ~dl_grant.map) == '0) else $error("fill off map");
    chk_retx_first: assert property (
        (dl_grant.retx & ~dl_grant.fill) == '0) else $error("retx off fill");
    chk_count_fill: assert property (
        $countones(dl_grant.fill) == dl_grant.valid_cnt)
        else $error("valid count differs from filled units");
    chk_req_code: assert property (
        tx_uplink_request_field[7] == 1'b0 && !tx_uplink_request_field[0])
        else $error("request field carries a reserved code");
    chk_req_write: assert property (wq |-> ##2
        tx_uplink_request_field == {$past(pwdata[7:1], 2), 1'b0})
        else $error("request field not taken from write");
    chk_short_group: assert property (wm |-> ##2
        mac_elems.short_elem[7:6] == $past(pwdata[1:0], 2))
        else $error("short element group wrong");
    chk_margin_rsv: assert property (wm |-> ##2
        mac_elems.margin_elem == {2'b00, $past(pwdata[13:8], 2)})
        else $error("margin element wrong");
    // Main scenarios reached
    cov_tick: cover property (tk);
    cov_rx: cover property (rx_req_valid);
    cov_err: cover property (acc && pslverr);
    cov_cancel: cover property (dl_grant.cancel && ul_grant.cancel);
endmodule : cfc_codec_chk
bind cfc_codec cfc_codec_chk cfc_codec_chk_inst (.pclk(pclk),
    .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .pslverr(pslverr), .frame_tick(frame_tick),
    .rx_req_valid(rx_req_valid), .dl_grant(dl_grant),
    .ul_grant(ul_grant), .mac_elems(mac_elems),
    .tx_uplink_request_field(tx_uplink_request_field));
`default_nettype wire

// [tb/cfc_peer.sv]
// Peer model: frame starts and request fields from the far side
`timescale 1ns/1ps
`default_nettype none
module cfc_peer (
    // Clock
    input  wire logic      pclk,
    // Toward the codec
    output var logic       frame_tick,
    output var logic       rx_req_valid,
    output var logic [7:0] rx_uplink_request_field
);
    // Idle levels at time zero
    initial
    begin
        frame_tick = 1'b0;
        rx_req_valid = 1'b0;
        rx_uplink_request_field = 8'h00;
    end
    // One frame start, then room for the grant to settle
    task tick();
        @(posedge pclk);
        frame_tick <= 1'b1;
        @(posedge pclk);
        frame_tick <= 1'b0;
        repeat (3) @(posedge pclk);
    endtask : tick
    // One request field; inverse afterwards so no stale copy is seen
    task send(input logic [7:0] fld);
        @(posedge pclk);
        rx_req_valid <= 1'b1;
        rx_uplink_request_field <= fld;
        @(posedge pclk);
        rx_req_valid <= 1'b0;
        rx_uplink_request_field <= ~fld;
        repeat (2) @(posedge pclk);
    endtask : send
endmodule : cfc_peer
`default_nettype wire

// [tb/tb.sv]
// Testbench: register, frame and request scenarios for the codec
`timescale 1ns/1ps
`default_nettype none
module tb;
    // Bus, frame and field signals
    logic              pclk, presetn, clk_en, psel, penable, pwrite;
    logic [7:0]        paddr, rx_uplink_request_field, tx_uplink_request_field;
    logic [31:0]       pwdata, prdata, rd;
    logic              pready, pslverr, er, frame_tick, rx_req_valid;
    cfc_pkg::cfc_dl_s  dl_grant;
    cfc_pkg::cfc_ul_s  ul_grant;
    cfc_pkg::cfc_mac_s mac_elems;
    int                n_fail = 0, checks_done = 0, cyc = 0;

    cfc_codec cfc_codec_inst (.pclk(pclk), .presetn(presetn),
        .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .frame_tick(frame_tick),
        .rx_req_valid(rx_req_valid), .dl_grant(dl_grant),
        .rx_uplink_request_field(rx_uplink_request_field),
        .ul_grant(ul_grant), .mac_elems(mac_elems),
        .tx_uplink_request_field(tx_uplink_request_field));
    cfc_peer cfc_peer_inst (.pclk(pclk), .frame_tick(frame_tick),
        .rx_req_valid(rx_req_valid),
        .rx_uplink_request_field(rx_uplink_request_field));

    // Clock
    initial
    begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    // Hang guard: whole run needs well under this
    always @(posedge pclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 5000)
        begin
            n_fail++;
            end_sim();
        end
    end

    task chk(input logic [71:0] got, input logic [71:0] exp, input string s);
        checks_done++;
        if (got !== exp)
        begin
            n_fail++;
            $display("CHECK FAILED at %0t: %s got %h", $time, s, got);
        end
    endtask : chk
    // One APB transfer; request held until pready is seen high
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task rdc(input logic [7:0] a, input logic [31:0] e, input string s);
        apb(1'b0, a, 32'h0000_0000);
        chk(rd, e, s);
    endtask : rdc

    task t_reset();
        rdc(cfc_pkg::OFS_CTRL, 32'h0000_0000, "ctrl reset");
        rdc(cfc_pkg::OFS_FRAME, 32'h0000_0000, "frame reset");
        apb(1'b0, 8'h30, 32'h0000_0000);
        chk({er, rd}, {1'b1, 32'h0000_0000}, "unmapped read");
        $display("test reset done");
    endtask : t_reset
    // Timing 1: two units of four valid, one of them retransmitted
    task t_grant();
        apb(1'b1, cfc_pkg::OFS_MAP0, 32'hF000_0000);
        apb(1'b1, cfc_pkg::OFS_DLTX, 32'h0001_0101);
        cfc_peer_inst.tick();
        chk(dl_grant.map, 72'hF << 68, "map");
        chk(dl_grant.fill, 72'h3 << 70, "fill");
        chk(dl_grant.retx, 72'h1 << 71, "retx");
        chk(dl_grant.valid_cnt, 7'h02, "count");
        chk(dl_grant.valid_field, 32'h0000_0002, "dl field");
        chk(dl_grant.cancel, 1'b1, "cancel");
        // Timing 2, version 2: new grant waits one extra frame
        apb(1'b1, cfc_pkg::OFS_CTRL, 32'h0000_0503);
        apb(1'b1, cfc_pkg::OFS_MAP0, 32'h8000_0000);
        apb(1'b1, cfc_pkg::OFS_MAP2, 32'h8000_0000);
        apb(1'b1, cfc_pkg::OFS_DLTX, 32'h0000_0500);
        cfc_peer_inst.tick();
        chk(dl_grant.map, 72'hF << 68, "map late");
        chk(dl_grant.cancel, 1'b1, "cancel late");
        cfc_peer_inst.tick();
        chk(dl_grant.map, 72'h80_0000_0000_0000_0080, "map due");
        chk(dl_grant.valid_cnt, 7'h02, "clamped count");
        chk(dl_grant.valid_field, 32'h0000_8001, "v2 field");
        chk(dl_grant.cancel, 1'b0, "cancel due");
        chk(dl_grant.origin, 7'h05, "origin");
        $display("test grant done");
    endtask : t_grant
    // Uplink applies at the next tick; a tick with clk_en low is lost
    task t_uplink();
        apb(1'b1, cfc_pkg::OFS_ULTX, 32'h8001_2345);
        cfc_peer_inst.tick();
        chk(ul_grant.valid_field, 32'h0001_2345, "ul field");
        chk(ul_grant.cancel, 1'b1, "ul cancel");
        apb(1'b1, cfc_pkg::OFS_ULTX, 32'h0000_0000);
        clk_en <= 1'b0;
        cfc_peer_inst.tick();
        clk_en <= 1'b1;
        chk(ul_grant.cancel, 1'b1, "frozen tick");
        cfc_peer_inst.tick();
        chk(ul_grant.cancel, 1'b0, "ul cancel off");
        $display("test uplink done");
    endtask : t_uplink
    // Request fields both ways; reserved codes change nothing
    task t_request();
        apb(1'b1, cfc_pkg::OFS_REQ, 32'h0000_005B);
        repeat (2) @(posedge pclk);
        chk(tx_uplink_request_field, 8'h5A, "margin req");
        apb(1'b1, cfc_pkg::OFS_REQ, 32'h0000_0027);
        repeat (2) @(posedge pclk);
        chk(tx_uplink_request_field, 8'h26, "size req");
        apb(1'b1, cfc_pkg::OFS_REQ, 32'h0000_00C3);
        repeat (2) @(posedge pclk);
        chk(tx_uplink_request_field, 8'h26, "reserved req");
        cfc_peer_inst.send(8'h3E);
        cfc_peer_inst.send(8'h4A);
        cfc_peer_inst.send(8'hFF);
        rdc(cfc_pkg::OFS_STATUS, 32'h0000_A3E3, "rx status");
        apb(1'b1, cfc_pkg::OFS_STATUS, 32'h0000_0003);
        rdc(cfc_pkg::OFS_STATUS, 32'h0000_A3E0, "status clear");
        $display("test request done");
    endtask : t_request
    // Group sizes saturate at 63; group 1 goes in the short element
    task t_mac();
        apb(1'b1, cfc_pkg::OFS_GSIZE01, 32'h0064_0005);
        apb(1'b1, cfc_pkg::OFS_GSIZE23, 32'h0000_003F);
        apb(1'b1, cfc_pkg::OFS_MACSEL, 32'h0000_2A01);
        repeat (2) @(posedge pclk);
        chk(mac_elems.short_elem, 8'h7F, "short");
        chk(mac_elems.long_elem, 24'h17_FFC0, "long");
        chk(mac_elems.margin_elem, 8'h2A, "margin");
        $display("test mac done");
    endtask : t_mac

    task end_sim();
        $display("checks %0d failures %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : end_sim

    // Main sequence
    initial
    begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        clk_en = 1'b1;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_grant();
        t_uplink();
        t_request();
        t_mac();
        end_sim();
    end
endmodule : tb
`default_nettype wire
